// [seq_cmd_pkg.sv]
package seq_cmd_pkg;

    // Dataway subaddress and function codes
    localparam logic [3:0] SUB_DATA = 4'h0;
    localparam logic [3:0] SUB_STATUS = 4'h1;
    localparam logic [3:0] SUB_POINTER = 4'h2;
    localparam logic [4:0] FN_READ = 5'h00;
    localparam logic [4:0] FN_READ_ID = 5'h06;
    localparam logic [4:0] FN_WRITE = 5'h10;
    localparam logic [4:0] FN_DISABLE = 5'h18;
    localparam logic [4:0] FN_ENABLE = 5'h1a;

    // Word widths and memory geometry
    localparam int DATA_W = 24;
    localparam int PTR_W = 10;
    localparam int CNT_W = 8;
    localparam int MEM_DEPTH = 1024;
    localparam logic [23:0] END_MARK = 24'hffffff;
    localparam logic [7:0] RECYCLE_RESET = 8'h00;

    // Status word field positions (read line n sits at bit n-1)
    localparam int ST_ENABLED = 0;
    localparam int ST_INT_CLK = 1;
    localparam int ST_MODE2 = 2;
    localparam int ST_RETRIG = 3;
    localparam int ST_DIV1 = 4;
    localparam int ST_DIV10 = 5;
    localparam int ST_DIV100 = 6;

    // Clock divide setting codes
    localparam logic [1:0] DIV_BY_1 = 2'h0;
    localparam logic [1:0] DIV_BY_10 = 2'h1;
    localparam logic [1:0] DIV_BY_100 = 2'h2;

    // Lamp stretch time
    localparam int CLK_PERIOD_NS = 10;
    localparam int LAMP_HOLD_MS = 100;
    localparam int LAMP_HOLD_CYC = (LAMP_HOLD_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // One dataway command cycle
    typedef struct packed {
        logic station;
        logic strobe;
        logic [3:0] sub;
        logic [4:0] fn;
        logic [23:0] wdata;
    } dw_cmd_t;

    // Dataway answer
    typedef struct packed {
        logic x;
        logic q;
        logic [23:0] rdata;
    } dw_resp_t;

    // Front-panel lamps
    typedef struct packed {
        logic station;
        logic armed;
        logic counting;
        logic output_on;
        logic cycle_start;
    } lamp_t;

endpackage : seq_cmd_pkg

// [lamp_stretch.sv]
`timescale 1ns/100ps
module lamp_stretch
    import seq_cmd_pkg::*;
#(
    parameter int HOLD_CYC = LAMP_HOLD_CYC
)(
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic level_i,
    output logic lamp_o
);
    localparam int CW = $clog2(HOLD_CYC + 1);

    initial
    begin
        if (HOLD_CYC < 1)
            $error("lamp_stretch: HOLD_CYC must be at least 1");
    end

    typedef struct packed {
        logic [CW-1:0] cnt;
        logic lamp;
    } stretch_state_t;

    stretch_state_t st_r;
    stretch_state_t st_nxt;

    // Reload while the source is high, count down after
    always_comb
    begin
        st_nxt = st_r;
        if (level_i)
            st_nxt.cnt = CW'(HOLD_CYC);
        else if (st_r.cnt != '0)
            st_nxt.cnt = st_r.cnt - 1'b1;
        // Lit through the whole hold count, so never shorter than the hold time
        st_nxt.lamp = level_i || (st_r.cnt != '0);
    end

    always_ff @(posedge clk_i)
    begin
        if (reset_i)
            st_r <= '0;
        else
            st_r <= st_nxt;
    end

    assign lamp_o = st_r.lamp;

    chk_lamp_follows_source: assert property (@(posedge clk_i) disable iff (reset_i) // see [R18] [R21] [R22]
        level_i |=> lamp_o)
        else $error("lamp not lit after source high");
endmodule : lamp_stretch

// [seq_cmd_port.sv]
`timescale 1ns/100ps
// Overview of operation
// [R1] A2 F16 loads pointer from W1-W10
// [R2] A0 F0 reads set point, advances pointer
// [R3] A0 F16 writes set point, advances pointer
// [R4] Disable halts cycle, outputs untouched
// [R5] Fixed-width mode: finish pulse, then low
// [R6] Variable-width mode: freeze output level
// [R7] Trigger accepted only after enable
// [R8] A0 F6 returns fixed identity word
// [R9] A1 F0 status: enabled, clock, mode, retrigger
// [R10] Divide bits 5-7, bits 8-24 zero
// [R11] Cycle end clears enabled unless retrigger
// [R12] A2 F0 returns pointer, upper bits zero
// [R13] A1 F16 loads recycle count, resets zero
// [R14] Reset on C, Z or power-on
// [R15] During cycle only starred commands act
// [R16] X high for implemented commands only
// [R17] Q high unless refused during cycle; code also gives Q low on unimplemented commands
// [R18] Station lamp stretched 0.1 s
// [R19] Armed lamp when enabled, not running
// [R20] Counting lamp while cycle runs
// [R21] Output lamp stretched 0.1 s
// [R22] Cycle-start lamp stretched 0.1 s
// [R23] Store holds 1024 words of 24 bits
// [R24] All-ones set point marks cycle end
// [R25] Pointer wraps 1023 to 0
module seq_cmd_port
    import seq_cmd_pkg::*;
#(
    parameter int DEPTH = MEM_DEPTH,
    parameter int LAMP_CYC = LAMP_HOLD_CYC,
    parameter logic [23:0] MODULE_ID = 24'h00a5c3 // Arbitrary value
)(
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic dw_clear_i,
    input wire logic dw_init_i,
    input dw_cmd_t cmd_i,
    output dw_resp_t resp_o,
    input wire logic mode2_sw_i,
    input wire logic int_clk_sw_i,
    input wire logic retrig_sw_i,
    input wire logic [1:0] div_sel_i,
    input wire logic cycle_start_i,
    input wire logic cycle_end_i,
    input wire logic pulse_level_i,
    input wire logic [PTR_W-1:0] engine_addr_i,
    output logic [DATA_W-1:0] engine_point_o,
    output logic engine_point_end_o,
    output logic trigger_enable_o,
    output logic running_o,
    output logic halt_o,
    output logic out_force_low_o,
    output logic out_freeze_o,
    output logic [CNT_W-1:0] recycle_count_o,
    output lamp_t lamp_o
);
    initial
    begin
        if (DEPTH != (1 << PTR_W))
            $error("seq_cmd_port: DEPTH must equal 2**PTR_W");
    end

    // All module state except the set-point store and lamp timers
    typedef struct packed {
        logic enabled;
        logic running;
        logic halt;
        logic force_low;
        logic freeze;
        logic [PTR_W-1:0] ptr;
        logic [CNT_W-1:0] recycle;
        logic [DATA_W-1:0] rdata;
        logic x;
        logic q;
    } port_state_t;

    port_state_t st_r;
    port_state_t st_nxt;
    logic [DATA_W-1:0] mem_r [DEPTH];
    logic [DATA_W-1:0] status_word;
    logic do_cmd;
    logic is_rd_pt;
    logic is_wr_pt;
    logic is_ld_ptr;
    logic is_rd_ptr;
    logic is_rd_st;
    logic is_wr_rc;
    logic is_id;
    logic is_dis;
    logic is_en;
    logic implemented;
    logic allowed;
    logic acts;
    logic any_reset;

    // Station and strobe are from the same-clock dataway front end
    assign do_cmd = cmd_i.station && cmd_i.strobe;
    assign any_reset = reset_i || dw_clear_i || dw_init_i; // see [R14]

    // Command decode
    assign is_rd_pt = cmd_i.sub == SUB_DATA && cmd_i.fn == FN_READ;
    assign is_wr_pt = cmd_i.sub == SUB_DATA && cmd_i.fn == FN_WRITE;
    assign is_id = cmd_i.sub == SUB_DATA && cmd_i.fn == FN_READ_ID;
    assign is_dis = cmd_i.sub == SUB_DATA && cmd_i.fn == FN_DISABLE;
    assign is_en = cmd_i.sub == SUB_DATA && cmd_i.fn == FN_ENABLE;
    assign is_rd_st = cmd_i.sub == SUB_STATUS && cmd_i.fn == FN_READ;
    assign is_wr_rc = cmd_i.sub == SUB_STATUS && cmd_i.fn == FN_WRITE;
    assign is_rd_ptr = cmd_i.sub == SUB_POINTER && cmd_i.fn == FN_READ;
    assign is_ld_ptr = cmd_i.sub == SUB_POINTER && cmd_i.fn == FN_WRITE;
    assign implemented = is_rd_pt | is_wr_pt | is_id | is_dis | is_en
                       | is_rd_st | is_wr_rc | is_rd_ptr | is_ld_ptr;
    // Commands still honoured while a cycle runs
    assign allowed = !st_r.running || is_dis || is_id || is_rd_st || is_rd_ptr; // see [R15]
    assign acts = do_cmd && implemented && allowed;

    // Status word assembly
    always_comb
    begin
        status_word = '0; // see [R10]
        status_word[ST_ENABLED] = st_r.enabled; // see [R9]
        status_word[ST_INT_CLK] = int_clk_sw_i;
        status_word[ST_MODE2] = mode2_sw_i;
        status_word[ST_RETRIG] = retrig_sw_i;
        status_word[ST_DIV1] = div_sel_i == DIV_BY_1; // see [R10]
        status_word[ST_DIV10] = div_sel_i == DIV_BY_10;
        status_word[ST_DIV100] = div_sel_i == DIV_BY_100;
    end

    // Next-state logic
    always_comb
    begin
        st_nxt = st_r;
        st_nxt.x = do_cmd && implemented; // see [R16]
        st_nxt.q = acts; // see [R17]
        if (cycle_start_i && st_r.enabled)
        begin
            st_nxt.running = 1'b1;
            st_nxt.halt = 1'b0;
            st_nxt.force_low = 1'b0;
            st_nxt.freeze = 1'b0;
        end
        if (cycle_end_i && st_r.running)
        begin
            st_nxt.running = 1'b0;
            if (!retrig_sw_i)
                st_nxt.enabled = 1'b0; // see [R11]
        end
        if (acts)
        begin
            if (is_ld_ptr)
                st_nxt.ptr = cmd_i.wdata[PTR_W-1:0]; // see [R1]
            if (is_rd_pt || is_wr_pt)
                st_nxt.ptr = st_r.ptr + 1'b1; // see [R2] [R3] [R25]
            if (is_rd_pt)
                st_nxt.rdata = mem_r[st_r.ptr]; // see [R2]
            if (is_id)
                st_nxt.rdata = MODULE_ID; // see [R8]
            if (is_rd_st)
                st_nxt.rdata = status_word; // see [R9]
            if (is_rd_ptr)
                st_nxt.rdata = {{(DATA_W-PTR_W){1'b0}}, st_r.ptr}; // see [R12]
            if (is_wr_rc)
                st_nxt.recycle = cmd_i.wdata[CNT_W-1:0]; // see [R13]
            if (is_en)
            begin
                st_nxt.enabled = 1'b1; // see [R7]
                st_nxt.force_low = 1'b0;
                st_nxt.freeze = 1'b0;
                st_nxt.halt = 1'b0;
            end
            if (is_dis)
            begin
                st_nxt.enabled = 1'b0;
                st_nxt.running = 1'b0; // see [R4]
                st_nxt.halt = 1'b1;
                st_nxt.force_low = !mode2_sw_i; // see [R5]
                st_nxt.freeze = mode2_sw_i; // see [R6]
            end
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (any_reset)
        begin
            st_r <= '0;
            st_r.recycle <= RECYCLE_RESET; // see [R13]
        end
        else
            st_r <= st_nxt;
    end

    // Set-point store, written only by the dataway
    always_ff @(posedge clk_i)
    begin
        if (acts && is_wr_pt)
            mem_r[st_r.ptr] <= cmd_i.wdata; // see [R3] [R23]
    end

    // Engine side of the store
    assign engine_point_o = mem_r[engine_addr_i];
    assign engine_point_end_o = mem_r[engine_addr_i] == END_MARK; // see [R24]

    assign resp_o.x = st_r.x;
    assign resp_o.q = st_r.q;
    assign resp_o.rdata = st_r.rdata;
    assign trigger_enable_o = st_r.enabled && !st_r.running; // see [R7]
    assign running_o = st_r.running;
    assign halt_o = st_r.halt;
    // Fixed-width: engine completes pulse then holds low
    assign out_force_low_o = st_r.force_low && !pulse_level_i; // see [R5]
    assign out_freeze_o = st_r.freeze; // see [R6]
    assign recycle_count_o = st_r.recycle;

    // Front-panel lamps
    assign lamp_o.armed = st_r.enabled && !st_r.running; // see [R19]
    assign lamp_o.counting = st_r.running; // see [R20]

    lamp_stretch #(.HOLD_CYC(LAMP_CYC)) u_lamp_n (
        .clk_i(clk_i), .reset_i(reset_i), .level_i(cmd_i.station), .lamp_o(lamp_o.station)); // see [R18]
    lamp_stretch #(.HOLD_CYC(LAMP_CYC)) u_lamp_o (
        .clk_i(clk_i), .reset_i(reset_i), .level_i(pulse_level_i), .lamp_o(lamp_o.output_on)); // see [R21]
    lamp_stretch #(.HOLD_CYC(LAMP_CYC)) u_lamp_r (
        .clk_i(clk_i), .reset_i(reset_i), .level_i(cycle_start_i), .lamp_o(lamp_o.cycle_start)); // see [R22]

    // Checks
    chk_ptr_load: assert property (@(posedge clk_i) disable iff (any_reset) // see [R1]
        acts && is_ld_ptr |=> st_r.ptr == $past(cmd_i.wdata[PTR_W-1:0]))
        else $error("pointer not loaded");
    chk_ptr_advance: assert property (@(posedge clk_i) disable iff (any_reset) // see [R25]
        acts && (is_rd_pt || is_wr_pt) |=> st_r.ptr == $past(st_r.ptr) + 1'b1)
        else $error("pointer not advanced");
    chk_id_word: assert property (@(posedge clk_i) disable iff (any_reset) // see [R8]
        acts && is_id |=> resp_o.rdata == MODULE_ID)
        else $error("identity word wrong");
    chk_status_top: assert property (@(posedge clk_i) disable iff (any_reset) // see [R10]
        acts && is_rd_st |=> resp_o.rdata[DATA_W-1:7] == '0)
        else $error("status upper bits not zero");
    chk_ptr_read: assert property (@(posedge clk_i) disable iff (any_reset) // see [R12]
        acts && is_rd_ptr |=> resp_o.rdata == {{(DATA_W-PTR_W){1'b0}}, $past(st_r.ptr)})
        else $error("pointer readback wrong");
    chk_x_unimpl: assert property (@(posedge clk_i) disable iff (any_reset) // see [R16]
        do_cmd && !implemented |=> !resp_o.x && !resp_o.q)
        else $error("X or Q on unimplemented command");
    chk_q_busy: assert property (@(posedge clk_i) disable iff (any_reset) // see [R17]
        do_cmd && st_r.running && (is_en || is_wr_pt) |=> resp_o.x && !resp_o.q)
        else $error("Q given to refused command");
    chk_disable_halt: assert property (@(posedge clk_i) disable iff (any_reset) // see [R4]
        acts && is_dis |=> !running_o && halt_o && !trigger_enable_o)
        else $error("disable did not halt");
    chk_enable_end: assert property (@(posedge clk_i) disable iff (any_reset) // see [R11]
        st_r.running && cycle_end_i && !retrig_sw_i && !(acts && is_en) |=> !st_r.enabled)
        else $error("enabled bit not cleared at cycle end");
endmodule : seq_cmd_port

// [dw_ctrl_model.sv]
`timescale 1ns/100ps
module dw_ctrl_model
    import seq_cmd_pkg::*;
(
    input wire logic clk_i,
    input dw_resp_t resp_i,
    output dw_cmd_t cmd_o
);
    dw_resp_t last_resp;
    initial cmd_o = '0;
    // One addressed strobe cycle, answer taken at the next falling edge
    task automatic issue(input logic [3:0] sub, input logic [4:0] fn, input logic [23:0] wd);
        @(negedge clk_i);
        cmd_o = '{station: 1'b1, strobe: 1'b1, sub: sub, fn: fn, wdata: wd};
        @(negedge clk_i);
        last_resp = resp_i;
        // Released write lines show the inverse of the last word
        cmd_o = '{station: 1'b0, strobe: 1'b0, sub: sub, fn: fn, wdata: ~wd};
        @(negedge clk_i);
    endtask : issue
endmodule : dw_ctrl_model

// [tb_top.sv]
`timescale 1ns/100ps
module tb_top;
    import seq_cmd_pkg::*;
    localparam int LAMP = 20;
    localparam logic [23:0] ID_WORD = 24'h5a0f3c; // Arbitrary value
    logic clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic clr = 1'b0;
    logic ini = 1'b0;
    logic m2 = 1'b0;
    logic ick = 1'b0;
    logic rtg = 1'b0;
    logic [1:0] div = 2'h0;
    logic start = 1'b0;
    logic fin = 1'b0;
    logic lvl = 1'b0;
    logic [PTR_W-1:0] eaddr = '0;
    dw_cmd_t cmd;
    dw_resp_t resp;
    logic [DATA_W-1:0] epoint;
    logic eend, trig_en, running, force_low, freeze, halt;
    logic [CNT_W-1:0] recyc;
    lamp_t lamp;
    int n_mismatch = 0;
    int checks_done = 0;
    int cycles = 0;

    seq_cmd_port #(.LAMP_CYC(LAMP), .MODULE_ID(ID_WORD)) dut (
        .clk_i(clk_i), .reset_i(reset_i), .dw_clear_i(clr), .dw_init_i(ini), .cmd_i(cmd), .resp_o(resp),
        .mode2_sw_i(m2), .int_clk_sw_i(ick), .retrig_sw_i(rtg), .div_sel_i(div), .cycle_start_i(start),
        .cycle_end_i(fin), .pulse_level_i(lvl), .engine_addr_i(eaddr), .engine_point_o(epoint),
        .engine_point_end_o(eend), .trigger_enable_o(trig_en), .running_o(running), .halt_o(halt),
        .out_force_low_o(force_low), .out_freeze_o(freeze), .recycle_count_o(recyc), .lamp_o(lamp));
    dw_ctrl_model ctrl (.clk_i(clk_i), .resp_i(resp), .cmd_o(cmd));

    always #5 clk_i = ~clk_i;
    // Cut a hang short
    always @(posedge clk_i)
    begin
        cycles <= cycles + 1;
        if (cycles == 2000)
        begin
            n_mismatch = n_mismatch + 1;
            finish_test();
        end
    end

    task automatic finish_test();
        $display("mismatches %0d checks %0d", n_mismatch, checks_done);
        if (n_mismatch == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : finish_test

    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic chk1(input logic seen, input logic exp);
        check({23'h0, seen}, {23'h0, exp});
    endtask : chk1

    // One command, X and Q judged
    task automatic cmd_xq(input logic [3:0] s, input logic [4:0] f, input logic [23:0] w, input logic x, input logic q);
        ctrl.issue(s, f, w);
        chk1(ctrl.last_resp.x, x);
        chk1(ctrl.last_resp.q, q);
    endtask : cmd_xq

    // Accepted read with expected word
    task automatic rd(input logic [3:0] s, input logic [4:0] f, input logic [23:0] exp);
        cmd_xq(s, f, 24'h0, 1'b1, 1'b1);
        check(ctrl.last_resp.rdata, exp);
    endtask : rd

    task automatic pulse(ref logic sig);
        @(negedge clk_i);
        sig = 1'b1;
        @(negedge clk_i);
        sig = 1'b0;
    endtask : pulse

    // State straight after reset
    task automatic t_reset();
        rd(SUB_STATUS, FN_READ, 24'h000010);
        rd(SUB_POINTER, FN_READ, 24'h0);
        check({16'h0, recyc}, 24'h0);
    endtask : t_reset

    // Switch and divider bits in the status word
    task automatic t_switches();
        logic [23:0] exp;
        for (int i = 0; i < 4; i++)
        begin
            {ick, m2} = i[1:0];
            rtg = ~i[0];
            div = i[1:0];
            exp = {17'h0, div == 2'h2, div == 2'h1, div == 2'h0, rtg, m2, ick, 1'b0};
            rd(SUB_STATUS, FN_READ, exp);
        end
        {ick, m2, rtg} = 3'h0;
        div = 2'h0;
    endtask : t_switches

    // Pointer load, writes across the wrap, readback
    task automatic t_memory();
        ctrl.issue(SUB_POINTER, FN_WRITE, 24'h5553fe);
        rd(SUB_POINTER, FN_READ, 24'h0003fe);
        ctrl.issue(SUB_DATA, FN_WRITE, 24'h0f1e2d);
        ctrl.issue(SUB_DATA, FN_WRITE, END_MARK);
        ctrl.issue(SUB_DATA, FN_WRITE, 24'h800001);
        rd(SUB_POINTER, FN_READ, 24'h000001);
        eaddr = 10'h3ff;
        #1 check(epoint, END_MARK);
        chk1(eend, 1'b1);
        eaddr = 10'h000;
        #1 check(epoint, 24'h800001);
        chk1(eend, 1'b0);
        ctrl.issue(SUB_POINTER, FN_WRITE, 24'h0003fe);
        rd(SUB_DATA, FN_READ, 24'h0f1e2d);
        rd(SUB_DATA, FN_READ, END_MARK);
        rd(SUB_DATA, FN_READ, 24'h800001);
    endtask : t_memory

    // Identity, unknown codes, recycle count, C and Z
    task automatic t_misc();
        rd(SUB_DATA, FN_READ_ID, ID_WORD);
        cmd_xq(4'h3, FN_READ, 24'h0, 1'b0, 1'b0);
        cmd_xq(SUB_DATA, 5'h01, 24'h0, 1'b0, 1'b0);
        cmd_xq(SUB_STATUS, FN_WRITE, 24'hffff81, 1'b1, 1'b1);
        check({16'h0, recyc}, 24'h000081);
        pulse(clr);
        @(negedge clk_i);
        check({16'h0, recyc}, 24'h0);
        ctrl.issue(SUB_POINTER, FN_WRITE, 24'h000005);
        pulse(ini);
        @(negedge clk_i);
        rd(SUB_POINTER, FN_READ, 24'h0);
    endtask : t_misc

    // Trigger gating, refusals while running, cycle end
    task automatic t_cycle(input logic r);
        rtg = r;
        pulse(start);
        repeat (2) @(negedge clk_i);
        chk1(running, 1'b0);
        cmd_xq(SUB_DATA, FN_ENABLE, 24'h0, 1'b1, 1'b1);
        chk1(trig_en, 1'b1);
        chk1(halt, 1'b0);
        chk1(lamp.armed, 1'b1);
        pulse(start);
        repeat (2) @(negedge clk_i);
        chk1(running, 1'b1);
        chk1(lamp.counting, 1'b1);
        chk1(lamp.cycle_start, 1'b1);
        chk1(lamp.armed, 1'b0);
        cmd_xq(SUB_POINTER, FN_WRITE, 24'h000007, 1'b1, 1'b0);
        cmd_xq(SUB_DATA, FN_ENABLE, 24'h0, 1'b1, 1'b0);
        rd(SUB_POINTER, FN_READ, 24'h0);
        pulse(fin);
        repeat (2) @(negedge clk_i);
        chk1(running, 1'b0);
        cmd_xq(SUB_STATUS, FN_READ, 24'h0, 1'b1, 1'b1);
        chk1(ctrl.last_resp.rdata[ST_ENABLED], r);
    endtask : t_cycle

    // Disable in mid-cycle with the output high
    task automatic t_disable(input logic m);
        m2 = m;
        rtg = 1'b0;
        cmd_xq(SUB_DATA, FN_ENABLE, 24'h0, 1'b1, 1'b1);
        pulse(start);
        lvl = 1'b1;
        @(negedge clk_i);
        cmd_xq(SUB_DATA, FN_DISABLE, 24'h0, 1'b1, 1'b1);
        chk1(running, 1'b0);
        chk1(halt, 1'b1);
        chk1(m ? freeze : force_low, m);
        chk1(m ? force_low : freeze, 1'b0);
        lvl = 1'b0;
        @(negedge clk_i);
        chk1(m ? freeze : force_low, 1'b1);
        chk1(lamp.output_on, 1'b1);
    endtask : t_disable

    // Stretch of the station and output lamps
    task automatic t_lamps();
        pulse(lvl);
        repeat (LAMP - 6) @(negedge clk_i);
        chk1(lamp.station, 1'b1);
        chk1(lamp.output_on, 1'b1);
        repeat (12) @(negedge clk_i);
        chk1(lamp.station, 1'b0);
        chk1(lamp.output_on, 1'b0);
    endtask : t_lamps

    // Main sequence
    initial
    begin
        repeat (5) @(negedge clk_i);
        reset_i = 1'b0;
        t_reset();
        t_switches();
        t_memory();
        t_misc();
        t_cycle(1'b0);
        t_cycle(1'b1);
        t_disable(1'b0);
        t_disable(1'b1);
        t_lamps();
        finish_test();
    end
endmodule : tb_top
